/* logic/rsf_reset_state.sv */
`timescale 1ns/1ns

// Functional notes
// - Every register except the decimal adjust result leaves reset at a defined value.
// - Source flags and voltage detect registers after reset depend on the reset source.
// - An illegal memory access reset sets the illegal-access flag, others held.
// - Every reset except a voltage-detector reset clears the select enable bit.
// - Non voltage-detector resets load the level from option bits: 00H, 81H or 01H.
// - All DMA registers of both channels clear to 00H on reset.
// - All six interrupt request flag registers clear to 00H on reset.
// - All twelve interrupt priority registers set to FFH on reset.
// - Rising and falling edge enable registers clear to 00H on reset.
// - CRC control and input clear to 00H, CRC results clear to 0000H.
// - Illegal access and RAM parity control registers clear to 00H.
// - Data flash control register clears to 00H on reset.
// - Decimal adjust result is not initialised by reset.
// - Pin reset, power-on reset or a flag read clears all five source flags.
// - Internal resets never clear the flags, they set only their own flag.
module rsf_reset_state
    import rsf_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        extPinReq,
    input  wire logic        porReq,
    input  wire logic        illegalInstrReq,
    input  wire logic        watchdogReq,
    input  wire logic        ramParityReq,
    input  wire logic        illegalAccessReq,
    input  wire logic        voltDetectReq,
    input  wire logic        voltModeOptHi,
    input  wire logic        voltModeOptLo,
    input  wire logic        voltDetectFlagIn,
    input  wire logic        voltDetectMaskIn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdData,
    output logic             resetAck,
    output logic             irq
);

    rsf_bank_if bankBus ();

    rsf_state_e state_q;
    rsf_state_e state_d;
    rsf_byte_t  resetSourceFlags_q;
    rsf_byte_t  resetSourceFlags_d;
    logic       voltDetectSelectEnable_q;
    logic       voltDetectSelectEnable_d;
    rsf_byte_t  voltDetectLevel_q;
    rsf_byte_t  voltDetectLevel_d;
    logic [15:0] flashCrcResult_q;
    logic [15:0] flashCrcResult_d;
    logic [15:0] crcData_q;
    logic [15:0] crcData_d;
    rsf_byte_t  decimalAdjustResult_q;
    rsf_byte_t  decimalAdjustResult_d;
    logic [`RSF_EV_COUNT-1:0] irqStatus_q;
    logic [`RSF_EV_COUNT-1:0] irqStatus_d;
    logic [`RSF_EV_COUNT-1:0] irqMask_q;
    logic [`RSF_EV_COUNT-1:0] irqMask_d;
    logic [`RSF_EV_COUNT-1:0] events;
    logic [15:0] localRd_q;
    logic [15:0] localRd_d;
    logic        bankSel_q;
    logic        bankSel_d;
    rsf_byte_t   hitMask;
    logic        clearAll;
    logic        internalReq;
    logic        nonVoltReq;
    logic        anyReq;
    logic        flagsRead;
    logic        swWr;

    // True when an address falls inside the peripheral register bank.
    function automatic logic isBankAddr(input logic [7:0] a);
        return a < 8'(`RSF_BANK_DEPTH);
    endfunction

    // Classification of the reset requests present in this cycle.
    assign clearAll    = extPinReq | porReq;
    assign internalReq = illegalInstrReq | watchdogReq | ramParityReq | illegalAccessReq
                       | voltDetectReq;
    assign nonVoltReq  = clearAll | illegalInstrReq | watchdogReq | ramParityReq
                       | illegalAccessReq;
    assign anyReq      = clearAll | internalReq;
    assign flagsRead   = regRd && regAddr == `RSF_A_FLAGS;
    assign swWr        = regWr && !anyReq;

    // Flag bits of every internal source present in this cycle.
    always_comb
    begin
        hitMask = `RSF_RV_CLEAR8;
        hitMask[`RSF_FLAG_TRAP] = illegalInstrReq;
        hitMask[`RSF_FLAG_WDOG] = watchdogReq;
        hitMask[`RSF_FLAG_RPAR] = ramParityReq;
        hitMask[`RSF_FLAG_IAW]  = illegalAccessReq;
        hitMask[`RSF_FLAG_VD]   = voltDetectReq;
    end

    // Acknowledge sequencer: any request restarts the acknowledge cycle.
    always_comb
    begin
        state_d = state_q;
        if (anyReq)
            state_d = ST_ACK;
        else
        begin
            case (state_q)
                ST_POR:  state_d = ST_ACK;
                ST_ACK:  state_d = ST_RUN;
                ST_RUN:  state_d = ST_RUN;
                default: state_d = ST_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            state_q <= ST_POR;
        else
            state_q <= state_d;
    end

    assign resetAck = state_q != ST_RUN;

    // Reset-source flags: pin and power-on clear, a read clears, sources set.
    always_comb
    begin
        resetSourceFlags_d = resetSourceFlags_q;
        if (clearAll)
            resetSourceFlags_d = `RSF_RV_CLEAR8;
        else
        begin
            if (flagsRead)
                resetSourceFlags_d = `RSF_RV_CLEAR8;
            resetSourceFlags_d = resetSourceFlags_d | hitMask;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            resetSourceFlags_q <= `RSF_RV_CLEAR8;
        else
            resetSourceFlags_q <= resetSourceFlags_d;
    end

    // Voltage detect select enable and level, held only by a detector reset.
    always_comb
    begin
        voltDetectSelectEnable_d = voltDetectSelectEnable_q;
        voltDetectLevel_d        = voltDetectLevel_q;
        if (nonVoltReq)
        begin
            voltDetectSelectEnable_d = 1'b0;
            voltDetectLevel_d = rsf_level_from_opt(voltModeOptHi, voltModeOptLo);
        end
        else if (state_q == ST_POR)
            voltDetectLevel_d = rsf_level_from_opt(voltModeOptHi, voltModeOptLo);
        else if (swWr && regAddr == `RSF_A_VD_CTRL && !voltDetectReq)
            voltDetectSelectEnable_d = regWrData[`RSF_VD_SEL_EN];
        else if (swWr && regAddr == `RSF_A_VD_LEVEL && !voltDetectReq)
            voltDetectLevel_d = regWrData[7:0];
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            voltDetectSelectEnable_q <= 1'b0;
            voltDetectLevel_q        <= `RSF_RV_CLEAR8;
        end
        else
        begin
            voltDetectSelectEnable_q <= voltDetectSelectEnable_d;
            voltDetectLevel_q        <= voltDetectLevel_d;
        end
    end

    // Sixteen-bit CRC result registers clear on every acknowledged reset.
    always_comb
    begin
        flashCrcResult_d = flashCrcResult_q;
        crcData_d        = crcData_q;
        if (anyReq)
        begin
            flashCrcResult_d = `RSF_RV_CLEAR16;
            crcData_d        = `RSF_RV_CLEAR16;
        end
        else if (swWr && regAddr == `RSF_A_FCRC_RESULT)
            flashCrcResult_d = regWrData;
        else if (swWr && regAddr == `RSF_A_CRC_DATA)
            crcData_d = regWrData;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flashCrcResult_q <= `RSF_RV_CLEAR16;
            crcData_q        <= `RSF_RV_CLEAR16;
        end
        else
        begin
            flashCrcResult_q <= flashCrcResult_d;
            crcData_q        <= crcData_d;
        end
    end

    // Decimal adjust result keeps whatever it holds across any reset.
    always_comb
    begin
        decimalAdjustResult_d = decimalAdjustResult_q;
        if (regWr && regAddr == `RSF_A_DEC_ADJ)
            decimalAdjustResult_d = regWrData[7:0];
    end

    always_ff @(posedge sys_clk)
    begin
        decimalAdjustResult_q <= decimalAdjustResult_d;
    end

    // Sticky event status with write-one-to-clear; a new event wins the clear.
    always_comb
    begin
        events = '0;
        events[`RSF_EV_EXT]  = extPinReq;
        events[`RSF_EV_POR]  = porReq;
        events[`RSF_EV_TRAP] = illegalInstrReq;
        events[`RSF_EV_WDOG] = watchdogReq;
        events[`RSF_EV_RPAR] = ramParityReq;
        events[`RSF_EV_IAW]  = illegalAccessReq;
        events[`RSF_EV_VD]   = voltDetectReq;
        irqStatus_d = irqStatus_q;
        irqMask_d   = irqMask_q;
        if (regWr && regAddr == `RSF_A_IRQ_STATUS)
            irqStatus_d = irqStatus_q & ~regWrData[`RSF_EV_COUNT-1:0];
        irqStatus_d = irqStatus_d | events;
        if (regWr && regAddr == `RSF_A_IRQ_MASK)
            irqMask_d = regWrData[`RSF_EV_COUNT-1:0];
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irqStatus_q <= '0;
            irqMask_q   <= '0;
        end
        else
        begin
            irqStatus_q <= irqStatus_d;
            irqMask_q   <= irqMask_d;
        end
    end

    assign irq = |(irqStatus_q & irqMask_q);

    // Bank access: an acknowledged reset reloads it and blocks software writes.
    assign bankBus.init   = anyReq;
    assign bankBus.wrEn   = swWr && isBankAddr(regAddr);
    assign bankBus.wrAddr = regAddr[5:0];
    assign bankBus.wrData = regWrData[7:0];
    assign bankBus.rdEn   = regRd && isBankAddr(regAddr);
    assign bankBus.rdAddr = regAddr[5:0];

    rsf_bank #(
        .DEPTH (`RSF_BANK_DEPTH)
    ) u_bank (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .bus     (bankBus)
    );

    // Read mux for the registers outside the bank; unmapped reads return zero.
    always_comb
    begin
        localRd_d = `RSF_RV_CLEAR16;
        bankSel_d = regRd && isBankAddr(regAddr);
        if (regRd)
        begin
            case (regAddr)
                `RSF_A_FLAGS:        localRd_d = {8'h00, resetSourceFlags_q};
                `RSF_A_VD_CTRL:
                begin
                    localRd_d[`RSF_VD_SEL_EN]   = voltDetectSelectEnable_q;
                    localRd_d[`RSF_VD_OUT_MASK] = voltDetectMaskIn;
                    localRd_d[`RSF_VD_FLAG]     = voltDetectFlagIn;
                end
                `RSF_A_VD_LEVEL:     localRd_d = {8'h00, voltDetectLevel_q};
                `RSF_A_FCRC_RESULT:  localRd_d = flashCrcResult_q;
                `RSF_A_CRC_DATA:     localRd_d = crcData_q;
                `RSF_A_DEC_ADJ:      localRd_d = {8'h00, decimalAdjustResult_q};
                `RSF_A_IRQ_STATUS:   localRd_d = {9'h000, irqStatus_q};
                `RSF_A_IRQ_MASK:     localRd_d = {9'h000, irqMask_q};
                default:             localRd_d = `RSF_RV_CLEAR16;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            localRd_q <= `RSF_RV_CLEAR16;
            bankSel_q <= 1'b0;
        end
        else
        begin
            localRd_q <= localRd_d;
            bankSel_q <= bankSel_d;
        end
    end

    assign regRdData = bankSel_q ? {8'h00, bankBus.rdData} : localRd_q;

    // Checks on the reset-state behaviour.
    sequence s_ack;
        anyReq;
    endsequence

    sequence s_cleanRead(logic [7:0] a);
        regRd && !regWr && regAddr == a && !anyReq;
    endsequence

    property p_trap_set;
        @(posedge sys_clk) disable iff (!rst_b)
        (illegalInstrReq && !clearAll) |=> resetSourceFlags_q[`RSF_FLAG_TRAP];
    endproperty
    a_trap_set: assert property (p_trap_set) else $error("trap flag not set");

    property p_iaw_set;
        @(posedge sys_clk) disable iff (!rst_b)
        (illegalAccessReq && !clearAll) |=> resetSourceFlags_q[`RSF_FLAG_IAW];
    endproperty
    a_iaw_set: assert property (p_iaw_set) else $error("access flag not set");

    property p_flags_held;
        @(posedge sys_clk) disable iff (!rst_b)
        (internalReq && !clearAll && !flagsRead)
        |=> ((resetSourceFlags_q & ~$past(hitMask)) == ($past(resetSourceFlags_q)
             & ~$past(hitMask)));
    endproperty
    a_flags_held: assert property (p_flags_held) else $error("flags not held");

    property p_pin_clears;
        @(posedge sys_clk) disable iff (!rst_b)
        clearAll |=> resetSourceFlags_q == `RSF_RV_CLEAR8;
    endproperty
    a_pin_clears: assert property (p_pin_clears) else $error("flags not cleared");

    property p_read_clears;
        @(posedge sys_clk) disable iff (!rst_b)
        s_cleanRead(`RSF_A_FLAGS) |=> (resetSourceFlags_q == `RSF_RV_CLEAR8)
        && (regRdData[7:0] == $past(resetSourceFlags_q));
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read clear failed");

    property p_sel_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        nonVoltReq |=> !voltDetectSelectEnable_q;
    endproperty
    a_sel_clear: assert property (p_sel_clear) else $error("select enable kept");

    property p_sel_held;
        @(posedge sys_clk) disable iff (!rst_b)
        (voltDetectReq && !nonVoltReq) |=> $stable(voltDetectSelectEnable_q);
    endproperty
    a_sel_held: assert property (p_sel_held) else $error("select enable changed");

    property p_level_opt;
        @(posedge sys_clk) disable iff (!rst_b)
        nonVoltReq |=> voltDetectLevel_q == rsf_level_from_opt($past(voltModeOptHi),
                                                              $past(voltModeOptLo));
    endproperty
    a_level_opt: assert property (p_level_opt) else $error("level not from options");

    property p_bank_after_ack(logic [7:0] a, logic [15:0] v);
        @(posedge sys_clk) disable iff (!rst_b)
        (s_ack ##1 s_cleanRead(a)) |=> regRdData == v;
    endproperty
    a_mask_set: assert property (p_bank_after_ack(8'h10, 16'h00FF))
        else $error("mask not FFH after reset");
    a_req_clear: assert property (p_bank_after_ack(8'h0A, 16'h0000))
        else $error("request flag not 00H after reset");
    a_prio_set: assert property (p_bank_after_ack(8'h21, 16'h00FF))
        else $error("priority not FFH after reset");
    a_dma_clear: assert property (p_bank_after_ack(8'h09, 16'h0000))
        else $error("DMA register not 00H after reset");
    a_crc_clear: assert property (p_bank_after_ack(`RSF_A_CRC_DATA, 16'h0000))
        else $error("CRC data not 0000H after reset");

endmodule

/* logic/rsf_params.svh */
`ifndef RSF_PARAMS_SVH
`define RSF_PARAMS_SVH

// Register port widths and bank depth.
`define RSF_AW              8
`define RSF_DW              16
`define RSF_BANK_DEPTH      43
`define RSF_BANK_AW         6

// Bank entry indices; the bank is reached at register addresses 00H..2AH.
`define RSF_IDX_DMA_PERIPH  6'h00
`define RSF_IDX_DMA_RAM     6'h02
`define RSF_IDX_DMA_COUNT   6'h04
`define RSF_IDX_DMA_MODE    6'h06
`define RSF_IDX_DMA_OPER    6'h08
`define RSF_IDX_IRQ_REQ     6'h0A
`define RSF_IDX_IRQ_MASK    6'h10
`define RSF_IDX_IRQ_PRIO    6'h16
`define RSF_IDX_IRQ_PRIO_END 6'h21
`define RSF_IDX_RISE_EDGE   6'h22
`define RSF_IDX_FALL_EDGE   6'h24
`define RSF_IDX_FCRC_CTRL   6'h26
`define RSF_IDX_CRC_IN      6'h27
`define RSF_IDX_IAW_CTRL    6'h28
`define RSF_IDX_RPAR_CTRL   6'h29
`define RSF_IDX_DFL_CTRL    6'h2A

// Addresses of the registers held outside the bank.
`define RSF_A_FLAGS         8'h30
`define RSF_A_VD_CTRL       8'h31
`define RSF_A_VD_LEVEL      8'h32
`define RSF_A_FCRC_RESULT   8'h33
`define RSF_A_CRC_DATA      8'h34
`define RSF_A_DEC_ADJ       8'h35
`define RSF_A_IRQ_STATUS    8'h38
`define RSF_A_IRQ_MASK      8'h39

// Reset-source flag bit positions.
`define RSF_FLAG_TRAP       7
`define RSF_FLAG_WDOG       4
`define RSF_FLAG_RPAR       2
`define RSF_FLAG_IAW        1
`define RSF_FLAG_VD         0

// Voltage detect control bit positions.
`define RSF_VD_SEL_EN       7
`define RSF_VD_OUT_MASK     1
`define RSF_VD_FLAG         0

// Reset values.
`define RSF_RV_CLEAR8       8'h00
`define RSF_RV_SET8         8'hFF
`define RSF_RV_CLEAR16      16'h0000
`define RSF_LEVEL_OPT_10    8'h00
`define RSF_LEVEL_OPT_11    8'h81
`define RSF_LEVEL_OPT_01    8'h01
`define RSF_LEVEL_OPT_00    8'h00

// Event bits of the interrupt status register.
`define RSF_EV_EXT          0
`define RSF_EV_POR          1
`define RSF_EV_TRAP         2
`define RSF_EV_WDOG         3
`define RSF_EV_RPAR         4
`define RSF_EV_IAW          5
`define RSF_EV_VD           6
`define RSF_EV_COUNT        7

`endif

/* logic/rsf_pkg.sv */
`include "rsf_params.svh"

package rsf_pkg;

    // Acknowledge sequencer states, Gray coded along POR, ACK, RUN.
    typedef enum logic [1:0]
    {
        ST_POR = 2'b00,
        ST_ACK = 2'b01,
        ST_RUN = 2'b11
    } rsf_state_e;

    typedef logic [7:0] rsf_byte_t;

    // Value that a bank entry takes when a reset is acknowledged.
    function automatic rsf_byte_t rsf_bank_reset_value(input int idx);
        if (idx >= int'(`RSF_IDX_IRQ_MASK) && idx <= int'(`RSF_IDX_IRQ_PRIO_END))
            return `RSF_RV_SET8;
        return `RSF_RV_CLEAR8;
    endfunction

    // Detection level chosen by the two option-byte mode bits.
    function automatic rsf_byte_t rsf_level_from_opt(input logic hi, input logic lo);
        case ({hi, lo})
            2'b10:   return `RSF_LEVEL_OPT_10;
            2'b11:   return `RSF_LEVEL_OPT_11;
            2'b01:   return `RSF_LEVEL_OPT_01;
            default: return `RSF_LEVEL_OPT_00;
        endcase
    endfunction

endpackage

/* logic/rsf_bank_if.sv */
`timescale 1ns/1ns

// Access port of the peripheral register bank.
interface rsf_bank_if;
    logic       init;
    logic       wrEn;
    logic [5:0] wrAddr;
    logic [7:0] wrData;
    logic       rdEn;
    logic [5:0] rdAddr;
    logic [7:0] rdData;

    modport ctl (output init, output wrEn, output wrAddr, output wrData,
                 output rdEn, output rdAddr, input rdData);
    modport mem (input init, input wrEn, input wrAddr, input wrData,
                 input rdEn, input rdAddr, output rdData);
endinterface

/* logic/rsf_bank.sv */
`timescale 1ns/1ns

module rsf_bank
    import rsf_pkg::*;
#(
    parameter int DEPTH = `RSF_BANK_DEPTH
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    rsf_bank_if.mem  bus
);

    rsf_byte_t memQ [DEPTH];
    rsf_byte_t memD [DEPTH];
    rsf_byte_t rdData_q;
    rsf_byte_t rdData_d;

    // Each entry loads its reset value on init, else takes a matching write.
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++)
        begin : g_entry
            always_comb
            begin
                memD[i] = memQ[i];
                if (bus.init)
                    memD[i] = rsf_bank_reset_value(i);
                else if (bus.wrEn && bus.wrAddr == 6'(i))
                    memD[i] = bus.wrData;
            end

            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                    memQ[i] <= rsf_bank_reset_value(i);
                else
                    memQ[i] <= memD[i];
            end
        end
    endgenerate

    // Read data come out of a register and are zero when no read was made.
    always_comb
    begin
        rdData_d = `RSF_RV_CLEAR8;
        if (bus.rdEn && int'(bus.rdAddr) < DEPTH)
            rdData_d = memQ[bus.rdAddr];
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdData_q <= `RSF_RV_CLEAR8;
        else
            rdData_q <= rdData_d;
    end

    assign bus.rdData = rdData_q;

endmodule

/* sim/testbench.sv */
`timescale 1ns/1ns
`include "rsf_params.svh"

module testbench;
    import rsf_pkg::*;

    logic        sys_clk;
    logic        rst_b;
    logic [6:0]  req;
    logic        optHi;
    logic        optLo;
    logic        vdIn;
    logic [7:0]  regAddr;
    logic [15:0] regWrData;
    logic        regWr;
    logic        regRd;
    logic [15:0] regRdData;
    logic        resetAck;
    logic        irq;
    logic [15:0] rd;
    int          error_cnt;
    int          checks;
    int          cycles;

    rsf_reset_state rsf_reset_state_inst (
        .sys_clk          (sys_clk),
        .rst_b            (rst_b),
        .extPinReq        (req[`RSF_EV_EXT]),
        .porReq           (req[`RSF_EV_POR]),
        .illegalInstrReq  (req[`RSF_EV_TRAP]),
        .watchdogReq      (req[`RSF_EV_WDOG]),
        .ramParityReq     (req[`RSF_EV_RPAR]),
        .illegalAccessReq (req[`RSF_EV_IAW]),
        .voltDetectReq    (req[`RSF_EV_VD]),
        .voltModeOptHi    (optHi),
        .voltModeOptLo    (optLo),
        .voltDetectFlagIn (vdIn),
        .voltDetectMaskIn (vdIn),
        .regAddr          (regAddr),
        .regWrData        (regWrData),
        .regWr            (regWr),
        .regRd            (regRd),
        .regRdData        (regRdData),
        .resetAck         (resetAck),
        .irq              (irq)
    );

    // The clock toggles every 20 ns, a period of 40 ns.
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Counts every comparison and reports a mismatch at once.
    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One write cycle on the register port.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr     <= 1'b0;
    endtask

    // One read cycle; the data are taken in the cycle after the strobe.
    task automatic rdchk(input string name, input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd   <= 1'b0;
        #1;
        cmp(name, exp, regRdData);
    endtask

    // Raises a set of reset requests for one cycle and checks the acknowledge.
    task automatic pulse(input logic [6:0] v);
        @(posedge sys_clk);
        req <= v;
        @(posedge sys_clk);
        req <= 7'h00;
        #1;
        cmp("resetAck", 16'h0001, {15'h0000, resetAck});
        @(posedge sys_clk);
        #1;
        cmp("resetAckDrop", 16'h0000, {15'h0000, resetAck});
    endtask

    // Writes a register, then reads it in the cycle right after a watchdog request.
    task automatic ackread(input logic [7:0] a, input logic [15:0] exp);
        wr(a, 16'h1234);
        @(posedge sys_clk);
        req <= 7'h08;
        @(posedge sys_clk);
        req     <= 7'h00;
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        cmp("ackRead", exp, regRdData);
    endtask

    // Registers read at once after an acknowledged reset already hold reset values.
    task automatic t_ack_read();
        ackread(8'h10, 16'h00FF);
        ackread(8'h0A, 16'h0000);
        ackread(8'h21, 16'h00FF);
        ackread(8'h09, 16'h0000);
        ackread(`RSF_A_CRC_DATA, 16'h0000);
    endtask

    // Compares every bank entry against its expected reset value.
    task automatic check_bank();
        for (int i = 0; i < `RSF_BANK_DEPTH; i++)
            rdchk("bank", 8'(i), (i >= 16 && i <= 33) ? 16'h00FF : 16'h0000);
        rdchk("crcResult", `RSF_A_FCRC_RESULT, 16'h0000);
        rdchk("crcData", `RSF_A_CRC_DATA, 16'h0000);
    endtask

    // Values after release of the power-on reset.
    task automatic t_power_on();
        check_bank();
        rdchk("flags", `RSF_A_FLAGS, 16'h0000);
        rdchk("level", `RSF_A_VD_LEVEL, 16'h0081);
        rdchk("unmapped", 8'h3F, 16'h0000);
    endtask

    // An internal reset reloads every register that was overwritten.
    task automatic t_reload();
        for (int i = 0; i < `RSF_BANK_DEPTH; i++)
            wr(8'(i), 16'h005A);
        wr(`RSF_A_CRC_DATA, 16'h1234);
        wr(`RSF_A_FCRC_RESULT, 16'h4321);
        pulse(7'h08);
        check_bank();
        rdchk("flags", `RSF_A_FLAGS, 16'h0010);
        rdchk("flagsCleared", `RSF_A_FLAGS, 16'h0000);
    endtask

    // Select enable and level survive a voltage reset only.
    task automatic t_volt();
        wr(`RSF_A_VD_CTRL, 16'h0080);
        wr(`RSF_A_VD_LEVEL, 16'h0033);
        pulse(7'h40);
        rdchk("selEn", `RSF_A_VD_CTRL, 16'h0083);
        rdchk("levelHeld", `RSF_A_VD_LEVEL, 16'h0033);
        pulse(7'h20);
        rdchk("selEnCleared", `RSF_A_VD_CTRL, 16'h0003);
        rdchk("levelLoaded", `RSF_A_VD_LEVEL, 16'h0081);
        pulse(7'h08);
        rdchk("flagsHeld", `RSF_A_FLAGS, 16'h0013);
    endtask

    // Simultaneous requests, then a pin reset that overrides a trap.
    task automatic t_multi();
        pulse(7'h14);
        rdchk("flagsBoth", `RSF_A_FLAGS, 16'h0084);
        pulse(7'h14);
        pulse(7'h05);
        rdchk("flagsPin", `RSF_A_FLAGS, 16'h0000);
        pulse(7'h02);
        rdchk("flagsPor", `RSF_A_FLAGS, 16'h0000);
    endtask

    // Each option setting selects its detection level.
    task automatic t_options();
        logic [3:0][1:0] opt;
        logic [3:0][7:0] lvl;
        opt = {2'b00, 2'b10, 2'b11, 2'b01};
        lvl = {8'h00, 8'h00, 8'h81, 8'h01};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            optHi <= opt[i][1];
            optLo <= opt[i][0];
            wr(`RSF_A_VD_LEVEL, 16'h0077);
            pulse(7'h10);
            rdchk("optLevel", `RSF_A_VD_LEVEL, {8'h00, lvl[i]});
        end
    endtask

    // Sticky event status, mask and the level interrupt.
    task automatic t_irq();
        wr(`RSF_A_IRQ_MASK, 16'h0000);
        wr(`RSF_A_IRQ_STATUS, 16'h007F);
        rdchk("status", `RSF_A_IRQ_STATUS, 16'h0000);
        pulse(7'h08);
        rdchk("statusSet", `RSF_A_IRQ_STATUS, 16'h0008);
        cmp("irqMasked", 16'h0000, {15'h0000, irq});
        wr(`RSF_A_IRQ_MASK, 16'h0008);
        @(posedge sys_clk);
        #1;
        cmp("irqOn", 16'h0001, {15'h0000, irq});
        wr(`RSF_A_IRQ_STATUS, 16'h0008);
        @(posedge sys_clk);
        #1;
        cmp("irqOff", 16'h0000, {15'h0000, irq});
    endtask

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            summarize();
        end
    end

    // Main sequence.
    initial
    begin
        rst_b     = 1'b0;
        req       = 7'h00;
        optHi     = 1'b1;
        optLo     = 1'b1;
        vdIn      = 1'b1;
        regAddr   = 8'h00;
        regWrData = 16'h0000;
        regWr     = 1'b0;
        regRd     = 1'b0;
        error_cnt = 0;
        checks    = 0;
        cycles    = 0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_power_on();
        t_reload();
        t_volt();
        t_multi();
        t_irq();
        t_options();
        t_ack_read();
        summarize();
    end
endmodule
